// *** rtl/gp_timer_pkg.sv ***
// Purpose: Constants and types shared by the general-purpose timer set
// Assumes: AHB-Lite word access, 16-bit registers in the low half of each word
// Notes: Each timer unit occupies one 0x40 window: control, count, period

package gp_timer_pkg;

   // ***************************************************************
   // Address map
   // ***************************************************************
   localparam int UNIT_COUNT = 5;
   localparam int UNIT_SHIFT = 6;
   localparam int SEL_SHIFT = 4;
   localparam int OP_SHIFT = 2;
   localparam logic [31:0] UNIT_STRIDE = 32'h0000_0040;
   localparam logic [31:0] REG_CONTROL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] REG_COUNT_OFFSET = 32'h0000_0010;
   localparam logic [31:0] REG_PERIOD_OFFSET = 32'h0000_0020;
   localparam logic [31:0] CLR_OFFSET = 32'h0000_0004;
   localparam logic [31:0] SET_OFFSET = 32'h0000_0008;
   localparam logic [31:0] INV_OFFSET = 32'h0000_000C;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ***************************************************************
   // Control field positions
   // ***************************************************************
   localparam int ON_BIT = 15;
   localparam int STOP_IN_IDLE_BIT = 13;
   localparam int WBLOCK_BIT = 12;
   localparam int WPEND_BIT = 11;
   localparam int ECS_LSB = 8;
   localparam int GATE_BIT = 7;
   localparam int PS_LSB = 4;
   localparam int JOIN_BIT = 3;
   localparam int SYNC_BIT = 2;
   localparam int CS_BIT = 1;

   // ***************************************************************
   // Implemented bits and reset values
   // ***************************************************************
   localparam logic [15:0] CTRL_A_MASK = 16'hB3B6;
   localparam logic [15:0] CTRL_B_EVEN_MASK = 16'hA0FA;
   localparam logic [15:0] CTRL_B_ODD_MASK = 16'hA0F2;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

   // ***************************************************************
   // Encodings
   // ***************************************************************
   localparam logic [1:0] ECS_SOSC = 2'h0;
   localparam logic [1:0] ECS_PIN = 2'h1;
   localparam logic [1:0] ECS_LOW_POWER_RC_CLOCK = 2'h2;
   localparam int PIN_SOSC = 0;
   localparam int PIN_A = 1;
   localparam int PIN_LOW_POWER_RC_CLOCK = 2;
   localparam int PIN_B0 = 3;
   localparam int PIN_COUNT = 7;

   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_CLR = 2'b01,
      OP_SET = 2'b10,
      OP_INV = 2'b11
   } op_t;

   typedef enum logic [1:0] {
      SEL_CONTROL = 2'b00,
      SEL_COUNT = 2'b01,
      SEL_PERIOD = 2'b10
   } reg_sel_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ_WAIT = 2'b10
   } bus_state_t;

   typedef struct packed {
      logic valid;
      logic [2:0] unit;
      reg_sel_t sel;
      op_t op;
   } decode_t;

   typedef struct packed {
      logic [15:0] count;
      logic match;
   } timebase_t;

endpackage : gp_timer_pkg

// *** rtl/gp_timer_set.sv ***
// Purpose: One type A and four type B 16-bit timers behind an AHB-Lite slave
// Assumes: Clock pins and oscillators are slow against hclk; idle_mode is on hclk
// Notes: Reads take one wait state, writes none
//
// What this block does
// - Control bit 15 on type A enables the timer; cleared disables it.
// - Bit 13 set halts timer in Idle; cleared keeps counting through Idle.
// - Bit 12 set drops type A count writes while one is pending.
// - Bit 11 reads 1 while async count write pending; 0 otherwise or synchronous.
// - Clock select 00 secondary osc, 01 clock pin, 10 low-power RC, 11 none.
// - Gate bit 7 gates counting only with the internal clock selected.
// - Type A prescale codes 00..11 divide by 1, 8, 64, 256.
// - Sync bit 2 set applies external-clock count writes at once; cleared holds them until the next clock edge; ignored when internal.
// - Clock source bit 1 selects external clock, else peripheral clock.
// - Unimplemented bits ignore writes and read zero.
// - Four independent 16-bit type B timers with internal, gated, external modes.
// - Timers 2/3 and 4/5 each join into one 32-bit timer.
// - Only timers 2 and 3 drive time base outputs.
// - ADC trigger from timer 3, or from the joined 2/3 pair.
// - Clear, set, invert aliases at offsets 0x4, 0x8, 0xC.
// - Type B prescale codes 000..111 divide by 1,2,4,8,16,32,64,256.
// - Join bit 3 on even timer forms one 32-bit timer.
// - When joined, odd timer control ignored; even control governs pair.
// - Type B clock source set counts own pin, cleared counts peripheral clock.

module gp_timer_set
   import gp_timer_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic idle_mode,
   input wire logic sosc_clock,
   input wire logic low_power_rc_clock,
   input wire logic type_a_ext_clock_pin,
   input wire logic [3:0] type_b_ext_clock_pin,
   output logic [4:0] timer_flag,
   output logic adc_trigger,
   output timebase_t time_base_2,
   output timebase_t time_base_3
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic decode_t decode(input logic [31:0] addr, input logic [2:0] size);
      decode_t d;
      d.unit = addr[UNIT_SHIFT +: 3];
      d.sel = reg_sel_t'(addr[SEL_SHIFT +: 2]);
      d.op = op_t'(addr[OP_SHIFT +: 2]);
      d.valid = (size == HSIZE_WORD) && (addr[1:0] == 2'b00)
                && ((addr >> (UNIT_SHIFT + 3)) == 32'h0000_0000)
                && (d.unit < 3'(UNIT_COUNT)) && (addr[SEL_SHIFT +: 2] != 2'b11);
      return d;
   endfunction

   function automatic logic [15:0] apply_op(input op_t op, input logic [15:0] old,
                                            input logic [15:0] wd);
      logic [15:0] r;
      r = wd;
      unique case (op)
         OP_WRITE: r = wd;
         OP_CLR: r = old & ~wd;
         OP_SET: r = old | wd;
         OP_INV: r = old ^ wd;
      endcase
      return r;
   endfunction

   function automatic logic [15:0] ctrl_mask(input logic [2:0] unit);
      logic [15:0] m;
      if (unit == 3'h0) begin
         m = CTRL_A_MASK;
      end else if (unit[0]) begin
         m = CTRL_B_EVEN_MASK;
      end else begin
         m = CTRL_B_ODD_MASK;
      end
      return m;
   endfunction

   function automatic logic [7:0] type_a_max(input logic [1:0] code);
      logic [7:0] m;
      unique case (code)
         2'h0: m = 8'h00;
         2'h1: m = 8'h07;
         2'h2: m = 8'h3F;
         2'h3: m = 8'hFF;
      endcase
      return m;
   endfunction

   function automatic logic [7:0] type_b_max(input logic [2:0] code);
      logic [7:0] m;
      unique case (code)
         3'h0: m = 8'h00;
         3'h1: m = 8'h01;
         3'h2: m = 8'h03;
         3'h3: m = 8'h07;
         3'h4: m = 8'h0F;
         3'h5: m = 8'h1F;
         3'h6: m = 8'h3F;
         3'h7: m = 8'hFF;
      endcase
      return m;
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   logic [PIN_COUNT-1:0] pin_meta_q, pin_sync_q, pin_prev_q;
   logic [PIN_COUNT-1:0] pin_rise;
   bus_state_t state_q;
   decode_t dp_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q, hresp_q;
   logic [15:0] ctrl_q [UNIT_COUNT];
   logic [15:0] cnt_q [UNIT_COUNT];
   logic [15:0] per_q [UNIT_COUNT];
   logic [7:0] pre_q [UNIT_COUNT];
   logic [4:0] flag_q;
   logic adc_q;
   logic pend_q;
   logic [15:0] pend_val_q;

   logic [15:0] eff [UNIT_COUNT];
   logic [7:0] pre_max [UNIT_COUNT];
   logic [4:0] run, evt, tick, hit16, wrap, wr_cnt;
   logic [15:0] nxt16 [UNIT_COUNT];
   logic [1:0] joined, hit32;
   logic [31:0] sum32 [2];
   logic ext_rise_a, async_a, pend_vis, pend_done, wr_en, accept;
   logic [15:0] rd_raw, wr_new;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_meta_q <= {type_b_ext_clock_pin, low_power_rc_clock, type_a_ext_clock_pin, sosc_clock};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   assign pin_rise = pin_sync_q & ~pin_prev_q;

   // ***************************************************************
   // AHB-Lite slave
   // ***************************************************************
   assign accept = hsel & htrans[1] & hready;
   assign wr_en = (state_q == BUS_WRITE) & dp_q.valid;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= BUS_IDLE;
         dp_q <= '0;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            BUS_READ_WAIT: begin
               hrdata_q <= {16'h0000, rd_raw};
               hreadyout_q <= 1'b1;
               state_q <= BUS_IDLE;
            end
            BUS_IDLE, BUS_WRITE: begin
               if (accept) begin
                  dp_q <= decode(haddr, hsize);
                  state_q <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
                  hreadyout_q <= hwrite;
               end else begin
                  state_q <= BUS_IDLE;
                  hreadyout_q <= 1'b1;
               end
            end
            default: begin
               state_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_q <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
      end
   end

   // Read value, also the old value for clear, set and invert
   always_comb begin
      rd_raw = 16'h0000;
      if (dp_q.valid) begin
         unique case (dp_q.sel)
            SEL_CONTROL: rd_raw = ctrl_q[dp_q.unit] | ((dp_q.unit == 3'h0 && pend_vis) ? (16'h0001 << WPEND_BIT) : 16'h0000);
            SEL_COUNT: rd_raw = cnt_q[dp_q.unit];
            SEL_PERIOD: rd_raw = per_q[dp_q.unit];
            default: rd_raw = 16'h0000;
         endcase
      end
   end

   assign wr_new = apply_op(dp_q.op, rd_raw, hwdata[15:0]);

   // ***************************************************************
   // Control and period registers
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < UNIT_COUNT; i++) begin
            ctrl_q[i] <= CTRL_RESET;
         end
      end else if (wr_en && dp_q.sel == SEL_CONTROL) begin
         ctrl_q[dp_q.unit] <= wr_new & ctrl_mask(dp_q.unit);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < UNIT_COUNT; i++) begin
            per_q[i] <= PERIOD_RESET;
         end
      end else if (wr_en && dp_q.sel == SEL_PERIOD) begin
         per_q[dp_q.unit] <= wr_new;
      end
   end

   // ***************************************************************
   // Clock selection, gating and prescalers
   // ***************************************************************
   always_comb begin
      unique case (ctrl_q[0][ECS_LSB +: 2])
         ECS_SOSC: ext_rise_a = pin_rise[PIN_SOSC];
         ECS_PIN: ext_rise_a = pin_rise[PIN_A];
         ECS_LOW_POWER_RC_CLOCK: ext_rise_a = pin_rise[PIN_LOW_POWER_RC_CLOCK];
         default: ext_rise_a = 1'b0;
      endcase
   end

   always_comb begin
      for (int i = 0; i < UNIT_COUNT; i++) begin
         eff[i] = ctrl_q[i];
      end
      for (int p = 0; p < 2; p++) begin
         joined[p] = ctrl_q[1 + 2 * p][JOIN_BIT];
         if (joined[p]) begin
            eff[2 + 2 * p] = ctrl_q[1 + 2 * p];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < UNIT_COUNT; i++) begin
         run[i] = eff[i][ON_BIT] & ~(eff[i][STOP_IN_IDLE_BIT] & idle_mode);
         if (i == 0) begin
            // Gate reads the clock pin level; external path per select field
            evt[i] = eff[i][CS_BIT] ? ext_rise_a : (eff[i][GATE_BIT] ? pin_sync_q[PIN_A] : 1'b1);
            pre_max[i] = type_a_max(eff[i][PS_LSB +: 2]);
         end else begin
            evt[i] = eff[i][CS_BIT] ? pin_rise[PIN_B0 + i - 1] :
                     (eff[i][GATE_BIT] ? pin_sync_q[PIN_B0 + i - 1] : 1'b1);
            pre_max[i] = type_b_max(eff[i][PS_LSB +: 3]);
         end
         tick[i] = run[i] & evt[i] & (pre_q[i] == pre_max[i]);
         hit16[i] = cnt_q[i] == per_q[i];
         nxt16[i] = cnt_q[i] + 16'h0001;
         wr_cnt[i] = wr_en && dp_q.sel == SEL_COUNT && dp_q.unit == 3'(i);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < UNIT_COUNT; i++) begin
            pre_q[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < UNIT_COUNT; i++) begin
            if (!eff[i][ON_BIT]) begin
               pre_q[i] <= 8'h00;
            end else if (run[i] && evt[i]) begin
               pre_q[i] <= (pre_q[i] == pre_max[i]) ? 8'h00 : pre_q[i] + 8'h01;
            end
         end
      end
   end

   // ***************************************************************
   // Pair arithmetic and period matches
   // ***************************************************************
   always_comb begin
      wrap[0] = tick[0] & hit16[0];
      for (int p = 0; p < 2; p++) begin
         hit32[p] = {cnt_q[2 + 2 * p], cnt_q[1 + 2 * p]} == {per_q[2 + 2 * p], per_q[1 + 2 * p]};
         sum32[p] = {cnt_q[2 + 2 * p], cnt_q[1 + 2 * p]} + 32'h0000_0001;
         if (joined[p]) begin
            wrap[1 + 2 * p] = 1'b0;
            wrap[2 + 2 * p] = tick[1 + 2 * p] & hit32[p];
         end else begin
            wrap[1 + 2 * p] = tick[1 + 2 * p] & hit16[1 + 2 * p];
            wrap[2 + 2 * p] = tick[2 + 2 * p] & hit16[2 + 2 * p];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= 5'h00;
         adc_q <= 1'b0;
      end else begin
         flag_q <= wrap;
         adc_q <= wrap[2];
      end
   end

   // ***************************************************************
   // Type A asynchronous write path
   // ***************************************************************
   assign async_a = ctrl_q[0][CS_BIT] & ~ctrl_q[0][SYNC_BIT];
   assign pend_vis = pend_q & async_a;
   assign pend_done = pend_q & (ext_rise_a | ~async_a);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= 1'b0;
         pend_val_q <= COUNT_RESET;
      end else if (wr_cnt[0] && async_a && !(pend_q && ctrl_q[0][WBLOCK_BIT])) begin
         pend_q <= 1'b1;
         pend_val_q <= wr_new;
      end else if (pend_done) begin
         pend_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Counters
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < UNIT_COUNT; i++) begin
            cnt_q[i] <= COUNT_RESET;
         end
      end else begin
         if (wr_cnt[0] && !async_a) begin
            cnt_q[0] <= wr_new;
         end else if (pend_done) begin
            cnt_q[0] <= pend_val_q;
         end else if (tick[0]) begin
            cnt_q[0] <= hit16[0] ? 16'h0000 : nxt16[0];
         end
         for (int p = 0; p < 2; p++) begin
            if (joined[p]) begin
               if (wr_cnt[1 + 2 * p]) begin
                  cnt_q[1 + 2 * p] <= wr_new;
               end else if (tick[1 + 2 * p]) begin
                  cnt_q[1 + 2 * p] <= hit32[p] ? 16'h0000 : sum32[p][15:0];
               end
               if (wr_cnt[2 + 2 * p]) begin
                  cnt_q[2 + 2 * p] <= wr_new;
               end else if (tick[1 + 2 * p]) begin
                  cnt_q[2 + 2 * p] <= hit32[p] ? 16'h0000 : sum32[p][31:16];
               end
            end else begin
               for (int k = 1; k < 3; k++) begin
                  if (wr_cnt[k + 2 * p]) begin
                     cnt_q[k + 2 * p] <= wr_new;
                  end else if (tick[k + 2 * p]) begin
                     cnt_q[k + 2 * p] <= hit16[k + 2 * p] ? 16'h0000 : nxt16[k + 2 * p];
                  end
               end
            end
         end
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign timer_flag = flag_q;
   assign adc_trigger = adc_q;
   assign time_base_2 = {cnt_q[1], flag_q[1]};
   assign time_base_3 = {cnt_q[2], flag_q[2]};

endmodule // gp_timer_set

// *** dv/gp_timer_assertions.sv ***
// Purpose: Port-level checks for the general-purpose timer set
// Assumes: One slave on the bus, hready tied to hreadyout
// Notes: Bound to the top module, sees its ports only
module gp_timer_assertions
   import gp_timer_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [4:0] timer_flag,
   input wire logic adc_trigger,
   input wire timebase_t time_base_2,
   input wire timebase_t time_base_3
);
   // ******************
   // Helpers
   // ******************
   logic take;
   logic wr_take;
   logic bad;
   assign take = hsel && htrans[1] && hready;
   assign wr_take = take && hwrite;
   assign bad = haddr >= 32'h140 || haddr[5:4] == 2'h3 || haddr[1:0] != 2'h0 || hsize != HSIZE_WORD;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence read_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence zero_answer;
      !hreadyout ##1 (hreadyout && hrdata == 32'h0);
   endsequence

   // ******************
   // Checks
   // ******************
   chk_read_wait: assert property (take && !hwrite |=> read_answer)
      else $error("read wait wrong");
   chk_write_nowait: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_unmapped_zero: assert property (take && !hwrite && bad |=> zero_answer)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   chk_adc_follows: assert property (adc_trigger == timer_flag[2])
      else $error("trigger apart from flag");
   chk_tb2_step: assert property ($changed(time_base_2.count) |->
      time_base_2.count == $past(time_base_2.count) + 16'h1 || time_base_2.count == 16'h0 || $past(wr_take, 2))
      else $error("timer2 count jumped");
   chk_tb3_step: assert property ($changed(time_base_3.count) |->
      time_base_3.count == $past(time_base_3.count) + 16'h1 || time_base_3.count == 16'h0 || $past(wr_take, 2))
      else $error("timer3 count jumped");
   chk_tb_match: assert property (time_base_2.match == timer_flag[1] && time_base_3.match == timer_flag[2])
      else $error("time base match apart from flag");
endmodule // gp_timer_assertions

bind gp_timer_set gp_timer_assertions gp_timer_assertions_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .timer_flag(timer_flag), .adc_trigger(adc_trigger),
   .time_base_2(time_base_2), .time_base_3(time_base_3));

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the general-purpose timer set
// Assumes: One slave on the bus, hready tied to hreadyout
// Notes: External sources toggle every 4 cycles
module tb_top
   import gp_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] b_on = 32'h8000;
   localparam logic [31:0] b_stop_in_idle = 32'h2000;
   localparam logic [31:0] b_blk = 32'h1000;
   localparam logic [31:0] b_pend = 32'h0800;
   localparam logic [31:0] b_gate = 32'h0080;
   localparam logic [31:0] b_join = 32'h0008;
   localparam logic [31:0] b_sync = 32'h0004;
   localparam logic [31:0] b_cs = 32'h0002;
   localparam int ra [4] = '{1, 8, 64, 256};
   localparam int rb [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
   localparam logic [31:0] imask [3] = '{32'hB3B6, 32'hA0FA, 32'hA0F2};
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic idle_mode;
   logic [6:0] ext_q;
   logic [4:0] timer_flag;
   logic adc_trigger;
   timebase_t time_base_2;
   timebase_t time_base_3;
   int mismatches;
   int n_compared;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;

   gp_timer_set gp_timer_set_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .idle_mode(idle_mode), .sosc_clock(ext_q[0]), .low_power_rc_clock(ext_q[2]),
      .type_a_ext_clock_pin(ext_q[1]), .type_b_ext_clock_pin(ext_q[6:3]), .timer_flag(timer_flag),
      .adc_trigger(adc_trigger), .time_base_2(time_base_2), .time_base_3(time_base_3));

   // ******************
   // Tasks
   // ******************
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] ad(input int u, input logic [31:0] o);
      return 32'(u) * UNIT_STRIDE + o;
   endfunction
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      r = hrdata;
      if (k >= 50) begin
         mismatches++;
         $display("wrong value at %0t: bus timeout", $time);
         complete_run();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      rd(a, r);
      chk(r, e);
   endtask
   // Clearing an on bit is followed by one quiet cycle
   task automatic off(input int u);
      wr(ad(u, REG_CONTROL_OFFSET), 32'h0);
      @(posedge hclk);
   endtask
   // Off first so the prescaler restarts clean
   task automatic arm(input int u, input logic [31:0] c, input logic [31:0] p, input logic [31:0] v);
      off(u);
      wr(ad(u, REG_COUNT_OFFSET), c);
      wr(ad(u, REG_PERIOD_OFFSET), p);
      wr(ad(u, REG_CONTROL_OFFSET), v);
   endtask
   // Counts flag pulses in a window opened by the first pulse
   task automatic flags(input int i, input int win, input int e);
      int t0;
      int n;
      int a;
      t0 = -1;
      n = 0;
      a = 0;
      for (int t = 0; t < 2 * win; t++) begin
         @(posedge hclk);
         if (t0 < 0 && t >= win) break;
         if (timer_flag[i] === 1'b1 && (t0 < 0 || t < t0 + win)) begin
            if (t0 < 0) t0 = t;
            n++;
         end
         if (adc_trigger === 1'b1 && t0 >= 0 && t < t0 + win) a++;
      end
      chk(n, e);
      if (i == 2) chk(a, e);
   endtask
   task automatic pulse(input int s, input int n);
      repeat (n) begin
         ext_q[s] <= 1'b1;
         repeat (4) @(posedge hclk);
         ext_q[s] <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask

   // ******************
   // Sequence
   // ******************
   initial begin
      logic [31:0] r;
      logic [31:0] v;
      logic [31:0] p;
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      idle_mode = 1'b0;
      ext_q = 7'h0;
      mismatches = 0;
      n_compared = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int u = 0; u < 5; u++) begin
         rdc(ad(u, REG_CONTROL_OFFSET), 32'h0);
         rdc(ad(u, REG_COUNT_OFFSET), 32'h0);
         rdc(ad(u, REG_PERIOD_OFFSET), 32'hFFFF);
      end
      for (int u = 0; u < 3; u++) begin
         wr(ad(u, REG_CONTROL_OFFSET), 32'hFFFF_FFFF);
         rdc(ad(u, REG_CONTROL_OFFSET), imask[u]);
         off(u);
      end
      rdc(32'h30, 32'h0);
      wr(32'h140, 32'hFFFF);
      rdc(32'h140, 32'h0);
      p = ad(1, REG_PERIOD_OFFSET);
      wr(p, 32'h1234_00F0);
      wr(p + SET_OFFSET, 32'h0F00);
      rdc(p, 32'h0FF0);
      wr(p + CLR_OFFSET, 32'h00F0);
      rdc(p, 32'h0F00);
      wr(p + INV_OFFSET, 32'hFFFF);
      rdc(p, 32'hF0FF);
      for (int c = 0; c < 4; c++) begin
         arm(0, 32'h0, 32'h1, b_on | (32'(c) << 4));
         flags(0, 8 * ra[c], 4);
      end
      arm(0, 32'h0, 32'h1, 32'h0);
      flags(0, 64, 0);
      for (int c = 0; c < 8; c++) begin
         arm(2, 32'h0, 32'h1, b_on | (32'(c) << 4));
         flags(2, 8 * rb[c], 4);
      end
      idle_mode <= 1'b1;
      arm(2, 32'h0, 32'h1, b_on | b_stop_in_idle);
      flags(2, 16, 0);
      wr(ad(2, REG_CONTROL_OFFSET), b_on);
      flags(2, 8, 4);
      idle_mode <= 1'b0;
      for (int q = 1; q < 4; q += 2) begin
         arm(q + 1, 32'h0, 32'h1, 32'h0070);
         arm(q, 32'hFFFE, 32'h0, b_on | b_join);
         flags(q + 1, 8, 1);
         flags(q, 8, 0);
         off(q);
      end
      arm(0, 32'h0, 32'h1, b_on | b_gate);
      flags(0, 16, 0);
      ext_q[1] <= 1'b1;
      flags(0, 8, 4);
      arm(0, 32'h0, 32'h1, b_on | b_gate | b_cs | b_sync | 32'h0100);
      flags(0, 16, 0);
      ext_q[1] <= 1'b0;
      for (int c = 0; c < 3; c++) begin
         arm(0, 32'h0, 32'h1, b_on | b_cs | b_sync | (32'(c) << 8));
         fork
            pulse(c, 20);
            flags(0, 64, 4);
         join
         fork
            pulse((c + 1) % 3, 20);
            flags(0, 64, 0);
         join
      end
      arm(0, 32'h0, 32'h1, b_on | b_cs | 32'h0100);
      fork
         pulse(1, 20);
         flags(0, 64, 4);
      join
      arm(4, 32'h0, 32'h1, b_on | b_cs);
      fork
         pulse(6, 20);
         flags(4, 64, 4);
      join
      arm(4, 32'h0, 32'h1, b_on | b_gate);
      flags(4, 16, 0);
      ext_q[6] <= 1'b1;
      flags(4, 8, 4);
      ext_q[6] <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         v = b_on | b_cs | 32'h0100 | (k == 0 ? b_blk : 32'h0);
         arm(0, 32'h0, 32'hFFFF, v);
         wr(ad(0, REG_COUNT_OFFSET), 32'h0100);
         wr(ad(0, REG_COUNT_OFFSET), 32'h0200);
         rdc(ad(0, REG_CONTROL_OFFSET), v | b_pend);
         pulse(1, 2);
         rdc(ad(0, REG_CONTROL_OFFSET), v);
         rd(ad(0, REG_COUNT_OFFSET), r);
         chk(r & 32'hFF00, k == 0 ? 32'h0100 : 32'h0200);
      end
      v = b_on | b_cs | b_sync | 32'h0100;
      arm(0, 32'h0, 32'hFFFF, v);
      wr(ad(0, REG_COUNT_OFFSET), 32'h0100);
      rdc(ad(0, REG_CONTROL_OFFSET), v);
      complete_run();
   end
endmodule // tb_top
